// file: fifo_pkg.sv
package fifo_pkg;

    localparam int DATA_W = 18;
    localparam int OFFSET_W = 12;
    localparam int DEPTH_DEFAULT = 256;
    localparam int STAGE_DEPTH = 16;
    // Wide enough for depth 4096 plus a 4095 offset without wrapping
    localparam int CMP_W = 14;
    localparam logic [DATA_W-1:0] DATA_RESET = 18'h00000;
    localparam logic [5:0] OFFSET_PAD = 6'h00;

    typedef enum {
        SEL_EMPTY,
        SEL_FULL
    } offset_sel_type;

    typedef struct packed {
        logic empty_n;
        logic almost_empty_n;
        logic half_full_n;
        logic almost_full_n;
        logic full_n;
    } flags_type;

    localparam flags_type FLAGS_RESET = '{
        empty_n: 1'b0,
        almost_empty_n: 1'b0,
        half_full_n: 1'b1,
        almost_full_n: 1'b1,
        full_n: 1'b1
    };

    typedef struct packed {
        logic [OFFSET_W-1:0] empty_off;
        logic [OFFSET_W-1:0] full_off;
    } offsets_type;

    function automatic logic [OFFSET_W-1:0] default_offset(input int depth);
        if (depth == 256) begin
            return 12'h01f;
        end
        if (depth == 512) begin
            return 12'h03f;
        end
        return 12'h07f;
    endfunction

    function automatic logic [CMP_W-1:0] widen(input logic [OFFSET_W-1:0] v);
        return {2'h0, v};
    endfunction

endpackage

// file: sync_fifo_prog_flags.sv
// Functional notes
// - Reset is required after power-up and leaves the FIFO empty, empty flag low.
// - During and after reset the output register holds zero, driven when enabled.
// - Write enable low stores the 18-bit input word on each write clock edge.
// - Read enable low presents the next stored word on each read clock edge.
// - Output enable high floats the data outputs; low drives the output register.
// - No cascading: data outputs are enabled by output enable alone, not by read enable.
// - While full flag is low, writes are ignored whatever write enable says.
// - While empty flag is low, reads are ignored whatever read enable says.
// - An empty FIFO keeps the last validly read word on its outputs.
// - Two 12-bit offset registers, loaded from input bits 0 to 11.
// - Load and write enable low write empty offset, then full, alternating.
// - Offset sequence position survives load going high; normal use resumes.
// - Load and read enable low read offsets out in the same alternating order.
// - Full flag changes only on write edges, empty flag only on read edges.
// - Sync select low clocks almost flags; otherwise they follow fill level live.
// - Almost empty low at count <= empty offset; almost full at >= depth - offset.
// - Empty at zero, half full above half depth, full at depth; flags active low.
// - Unprogrammed offsets are 31, 63 or 127 depending on depth.
// - A high retransmit pulse returns the read pointer to the first location.
// - After retransmit reads replay old data up to the write pointer, flags tracking.
// - Half-full pin is only the half-full flag; there is no write cascade output.
`timescale 1ns/1ns

module stage_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 16
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_q;
    logic [AW:0] wr_d;
    logic [AW:0] rd_q;
    logic [AW:0] rd_d;

    assign level = wr_q - rd_q;
    assign in_ready = level != (AW+1)'(DEPTH);
    assign out_valid = level != '0;
    assign out_data = mem[rd_q[AW-1:0]];

    always_comb begin
        wr_d = wr_q;
        rd_d = rd_q;
        if (in_valid && in_ready) begin
            wr_d = wr_q + 1'b1;
        end
        if (out_valid && out_ready) begin
            rd_d = rd_q + 1'b1;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
        end
    end

    // Storage has no reset; contents are only read behind a valid pointer
    always_ff @(posedge clock) begin
        if (in_valid && in_ready) begin
            mem[wr_q[AW-1:0]] <= in_data;
        end
    end
endmodule // stage_fifo

module sync_fifo_prog_flags
    import fifo_pkg::*;
#(
    parameter int DEPTH = DEPTH_DEFAULT
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic write_clk,
    input wire logic write_enable_n,
    input wire logic [DATA_W-1:0] data_in,
    input wire logic read_clk,
    input wire logic read_enable_n,
    input wire logic output_enable_n,
    input wire logic offset_load_n,
    input wire logic retransmit_pulse,
    input wire logic flag_sync_select_n,
    output logic [DATA_W-1:0] data_out,
    output logic data_out_oe_n,
    output logic empty_flag_n,
    output logic full_flag_n,
    output logic almost_empty_flag_n,
    output logic almost_full_flag_n,
    output logic half_full_flag_n
);
    localparam int AW = $clog2(DEPTH);
    localparam int SW = $clog2(STAGE_DEPTH);
    localparam logic [CMP_W-1:0] DEPTH_C = CMP_W'(DEPTH);
    localparam logic [CMP_W-1:0] HALF_C = CMP_W'(DEPTH / 2);
    localparam logic [AW:0] DEPTH_P = (AW+1)'(DEPTH);
    localparam logic [OFFSET_W-1:0] OFFSET_DEFAULT = default_offset(DEPTH);

    // Pin sampling for edge detection of the port clocks
    logic wclk_q;
    logic rclk_q;
    logic wr_edge;
    logic rd_edge;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            wclk_q <= 1'b0;
            rclk_q <= 1'b0;
        end else begin
            wclk_q <= write_clk;
            rclk_q <= read_clk;
        end
    end

    assign wr_edge = write_clk & ~wclk_q;
    assign rd_edge = read_clk & ~rclk_q;

    // Write staging buffer and main array
    logic [DATA_W-1:0] mem_q [DEPTH];
    logic [AW:0] wptr_q;
    logic [AW:0] wptr_d;
    logic [AW:0] rptr_q;
    logic [AW:0] rptr_d;
    logic [AW:0] arr_cnt;
    logic push;
    logic pop;
    logic stage_in_ready;
    logic stage_out_valid;
    logic stage_out_ready;
    logic drain;
    logic [DATA_W-1:0] stage_data;
    logic [SW:0] stage_level;
    logic [CMP_W-1:0] total_c;
    logic [CMP_W-1:0] arr_c;
    flags_type flags_q;
    flags_type flags_d;

    assign arr_cnt = wptr_q - rptr_q;
    assign arr_c = CMP_W'(arr_cnt);
    assign total_c = arr_c + CMP_W'(stage_level);
    assign push = wr_edge && offset_load_n && !write_enable_n
        && flags_q.full_n && stage_in_ready;
    assign pop = rd_edge && offset_load_n && !read_enable_n
        && flags_q.empty_n && arr_cnt != '0 && !retransmit_pulse;
    assign stage_out_ready = arr_cnt != DEPTH_P;
    assign drain = stage_out_valid && stage_out_ready;

    // Staging absorbs a write edge while the array slot is updated a clock later
    stage_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(STAGE_DEPTH)
    ) u_stage (
        .clock(clock),
        .arst_n(arst_n),
        .in_valid(push),
        .in_ready(stage_in_ready),
        .in_data(data_in),
        .out_valid(stage_out_valid),
        .out_ready(stage_out_ready),
        .out_data(stage_data),
        .level(stage_level)
    );

    always_comb begin
        wptr_d = wptr_q;
        rptr_d = rptr_q;
        if (drain) begin
            wptr_d = wptr_q + 1'b1;
        end
        if (retransmit_pulse) begin
            rptr_d = '0;
        end else if (pop) begin
            rptr_d = rptr_q + 1'b1;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            wptr_q <= '0;
            rptr_q <= '0;
        end else begin
            wptr_q <= wptr_d;
            rptr_q <= rptr_d;
        end
    end

    always_ff @(posedge clock) begin
        if (drain) begin
            mem_q[wptr_q[AW-1:0]] <= stage_data;
        end
    end

    // Offset registers and their sequence positions
    offsets_type off_q;
    offsets_type off_d;
    offset_sel_type wsel_q;
    offset_sel_type wsel_d;
    offset_sel_type rsel_q;
    offset_sel_type rsel_d;
    logic wr_offset;
    logic rd_offset;

    assign wr_offset = wr_edge && !offset_load_n && !write_enable_n;
    assign rd_offset = rd_edge && !offset_load_n && !read_enable_n;

    always_comb begin
        off_d = off_q;
        wsel_d = wsel_q;
        rsel_d = rsel_q;
        if (wr_offset) begin
            case (wsel_q)
                SEL_EMPTY: begin
                    off_d.empty_off = data_in[OFFSET_W-1:0];
                    wsel_d = SEL_FULL;
                end
                SEL_FULL: begin
                    off_d.full_off = data_in[OFFSET_W-1:0];
                    wsel_d = SEL_EMPTY;
                end
                default: begin
                    wsel_d = SEL_EMPTY;
                end
            endcase
        end
        if (rd_offset) begin
            case (rsel_q)
                SEL_EMPTY: begin
                    rsel_d = SEL_FULL;
                end
                SEL_FULL: begin
                    rsel_d = SEL_EMPTY;
                end
                default: begin
                    rsel_d = SEL_EMPTY;
                end
            endcase
        end
    end

    // Sequence positions only move on a load access, so they persist across normal use
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            off_q <= '{empty_off: OFFSET_DEFAULT, full_off: OFFSET_DEFAULT};
            wsel_q <= SEL_EMPTY;
            rsel_q <= SEL_EMPTY;
        end else begin
            off_q <= off_d;
            wsel_q <= wsel_d;
            rsel_q <= rsel_d;
        end
    end

    // Output register
    logic [DATA_W-1:0] dout_q;
    logic [DATA_W-1:0] dout_d;

    always_comb begin
        dout_d = dout_q;
        if (rd_offset) begin
            if (rsel_q == SEL_EMPTY) begin
                dout_d = {OFFSET_PAD, off_q.empty_off};
            end else begin
                dout_d = {OFFSET_PAD, off_q.full_off};
            end
        end else if (pop) begin
            dout_d = mem_q[rptr_q[AW-1:0]];
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            dout_q <= DATA_RESET;
        end else begin
            dout_q <= dout_d;
        end
    end

    assign data_out = dout_q;
    // No cascade logic here: a device drives only under its own enable
    assign data_out_oe_n = output_enable_n;

    // Flags: one clock domain, so both pointers are compared directly
    logic [CMP_W-1:0] total_after;
    logic [CMP_W-1:0] arr_after;
    logic pae_live;
    logic paf_live;

    assign total_after = total_c + CMP_W'(push);
    assign arr_after = arr_c - CMP_W'(pop);
    assign pae_live = !(arr_c <= widen(off_q.empty_off));
    assign paf_live = !(total_c + widen(off_q.full_off) >= DEPTH_C);

    always_comb begin
        flags_d = flags_q;
        if (wr_edge) begin
            flags_d.full_n = total_after != DEPTH_C;
            flags_d.half_full_n = !(total_after > HALF_C);
            flags_d.almost_full_n = !(total_after + widen(off_q.full_off) >= DEPTH_C);
        end
        if (rd_edge) begin
            flags_d.empty_n = arr_after != '0;
            flags_d.almost_empty_n = !(arr_after <= widen(off_q.empty_off));
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            flags_q <= FLAGS_RESET;
        end else begin
            flags_q <= flags_d;
        end
    end

    assign empty_flag_n = flags_q.empty_n;
    assign full_flag_n = flags_q.full_n;
    assign half_full_flag_n = flags_q.half_full_n;
    assign almost_empty_flag_n = flag_sync_select_n ? pae_live : flags_q.almost_empty_n;
    assign almost_full_flag_n = flag_sync_select_n ? paf_live : flags_q.almost_full_n;

    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);

    empty_on_read_edge_a: assert property (
        !rd_edge |=> $stable(empty_flag_n))
        else $error("empty flag moved without a read edge");

    full_on_write_edge_a: assert property (
        !wr_edge |=> $stable(full_flag_n))
        else $error("full flag moved without a write edge");

    overflow_block_a: assert property (
        (!full_flag_n && offset_load_n) |=> $stable(total_c) || !$stable(rptr_q))
        else $error("write accepted while full");

    underflow_block_a: assert property (
        (rd_edge && !empty_flag_n && !retransmit_pulse) |=> $stable(rptr_q))
        else $error("read accepted while empty");

    read_advance_a: assert property (
        (rd_edge && offset_load_n && !read_enable_n && empty_flag_n && !retransmit_pulse)
        |=> rptr_q == $past(rptr_q) + 1'b1 && data_out == mem_q[$past(rptr_q[AW-1:0])])
        else $error("read did not advance or present data");

    last_word_hold_a: assert property (
        (!empty_flag_n && offset_load_n) |=> $stable(data_out))
        else $error("output changed while empty");

    offset_sequence_a: assert property (
        (wr_offset && wsel_q == SEL_EMPTY) |=> off_q.empty_off == $past(data_in[OFFSET_W-1:0])
        && wsel_q == SEL_FULL ##1 (wsel_q == SEL_FULL) [*1])
        else $error("empty offset load out of sequence");

    retransmit_ptr_a: assert property (
        retransmit_pulse |=> rptr_q == '0)
        else $error("retransmit did not rewind read pointer");

    almost_empty_live_a: assert property (
        flag_sync_select_n |-> almost_empty_flag_n == !(arr_c <= widen(off_q.empty_off)))
        else $error("almost empty flag disagrees with fill level");

endmodule // sync_fifo_prog_flags

// file: fifo_port_agent.sv
`timescale 1ns/1ns

module fifo_port_agent
    import fifo_pkg::*;
(
    input wire logic clock,
    output logic write_clk,
    output logic write_enable_n,
    output logic [DATA_W-1:0] data_in,
    output logic read_clk,
    output logic read_enable_n,
    output logic offset_load_n,
    output logic retransmit_pulse
);
    // Port clocks stand low outside transfers so no stray rise is seen at reset release
    initial begin
        write_clk = 1'b0;
        write_enable_n = 1'b1;
        data_in = '0;
        read_clk = 1'b0;
        read_enable_n = 1'b1;
        offset_load_n = 1'b1;
        retransmit_pulse = 1'b0;
    end

    task automatic wr(input logic load_n, input logic en_n, input logic [DATA_W-1:0] d);
        @(posedge clock);
        #1;
        write_clk = 1'b1;
        write_enable_n = en_n;
        offset_load_n = load_n;
        data_in = d;
        @(posedge clock);
        #1;
        write_clk = 1'b0;
        write_enable_n = 1'b1;
        offset_load_n = 1'b1;
        // Released data must not keep showing the old word
        data_in = ~d;
    endtask

    task automatic rd(input logic load_n, input logic en_n);
        @(posedge clock);
        #1;
        read_clk = 1'b1;
        read_enable_n = en_n;
        offset_load_n = load_n;
        @(posedge clock);
        #1;
        read_clk = 1'b0;
        read_enable_n = 1'b1;
        offset_load_n = 1'b1;
    endtask

    task automatic retransmit();
        @(posedge clock);
        #1;
        retransmit_pulse = 1'b1;
        @(posedge clock);
        #1;
        retransmit_pulse = 1'b0;
        repeat (2) @(posedge clock);
    endtask
endmodule // fifo_port_agent

// file: test_sync_fifo_prog_flags.sv
`timescale 1ns/1ns

module test_sync_fifo_prog_flags
    import fifo_pkg::*;
();
    localparam int DEPTH_T = 256;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic output_enable_n = 1'b0;
    logic write_clk, write_enable_n, read_clk, read_enable_n, offset_load_n, retransmit_pulse;
    logic [DATA_W-1:0] data_in;
    logic [DATA_W-1:0] data_out;
    logic data_out_oe_n, empty_flag_n, full_flag_n, almost_empty_flag_n, almost_full_flag_n;
    logic half_full_flag_n;
    logic [DATA_W-1:0] mem [DEPTH_T];
    logic [DATA_W-1:0] last = '0;
    logic [31:0] seed = 32'h00000033;
    logic wsel = 1'b0;
    logic rsel = 1'b0;
    logic ef_seen = 1'b0;
    logic flag_sync_select_n = 1'b0;
    int wptr = 0;
    int rptr = 0;
    int eoff = 31;
    int foff = 31;
    int error_cnt = 0;
    int comparisons = 0;

    always #4 clock = ~clock;

    fifo_port_agent i_fifo_port_agent (
        .clock(clock), .write_clk(write_clk), .write_enable_n(write_enable_n),
        .data_in(data_in), .read_clk(read_clk), .read_enable_n(read_enable_n),
        .offset_load_n(offset_load_n), .retransmit_pulse(retransmit_pulse)
    );

    sync_fifo_prog_flags #(.DEPTH(DEPTH_T)) i_sync_fifo_prog_flags (
        .clock(clock), .arst_n(arst_n), .write_clk(write_clk),
        .write_enable_n(write_enable_n), .data_in(data_in), .read_clk(read_clk),
        .read_enable_n(read_enable_n), .output_enable_n(output_enable_n),
        .offset_load_n(offset_load_n), .retransmit_pulse(retransmit_pulse),
        .flag_sync_select_n(flag_sync_select_n), .data_out(data_out),
        .data_out_oe_n(data_out_oe_n),
        .empty_flag_n(empty_flag_n), .full_flag_n(full_flag_n),
        .almost_empty_flag_n(almost_empty_flag_n), .almost_full_flag_n(almost_full_flag_n),
        .half_full_flag_n(half_full_flag_n)
    );

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic chk_bit(input logic got, input logic exp, input string what);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: %s flag got %b", $time, what, got);
        end
    endtask

    task automatic chk_word(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp,
                            input string what);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic push(input logic [DATA_W-1:0] d);
        int cnt;
        cnt = wptr - rptr;
        output_enable_n = ^d;
        i_fifo_port_agent.wr(1'b1, 1'b0, d);
        if (cnt < DEPTH_T) begin
            mem[wptr % DEPTH_T] = d;
            wptr++;
        end
        cnt = wptr - rptr;
        chk_bit(full_flag_n, cnt < DEPTH_T, "full");
        chk_bit(half_full_flag_n, cnt <= DEPTH_T / 2, "half");
        chk_bit(almost_full_flag_n, cnt + foff < DEPTH_T, "afull");
        chk_bit(data_out_oe_n, output_enable_n, "oe");
    endtask

    // The empty flag only refreshes on a read rise, so acceptance follows the last seen flag
    // With a single device the combined empty flag is this device's own flag
    task automatic pop(input logic en_n);
        if (!en_n && ef_seen) begin
            last = mem[rptr % DEPTH_T];
            rptr++;
        end
        i_fifo_port_agent.rd(1'b1, en_n);
        ef_seen = wptr != rptr;
        chk_word(data_out, last, "data");
        chk_bit(empty_flag_n, ef_seen, "empty");
        chk_bit(almost_empty_flag_n, wptr - rptr > eoff, "aempty");
        // Live mode must follow reads even without a write rise
        if (flag_sync_select_n) begin
            chk_bit(almost_full_flag_n, wptr - rptr + foff < DEPTH_T, "afull live");
        end
    endtask

    task automatic offs_wr(input logic en_n, input logic [DATA_W-1:0] d);
        i_fifo_port_agent.wr(1'b0, en_n, d);
        if (!en_n) begin
            if (wsel) begin
                foff = int'(d[OFFSET_W-1:0]);
            end else begin
                eoff = int'(d[OFFSET_W-1:0]);
            end
            wsel = !wsel;
        end
    endtask

    task automatic offs_rd();
        i_fifo_port_agent.rd(1'b0, 1'b0);
        // Any read rise refreshes the empty flag, offset reads included
        ef_seen = wptr != rptr;
        last = {OFFSET_PAD, rsel ? foff[OFFSET_W-1:0] : eoff[OFFSET_W-1:0]};
        rsel = !rsel;
        chk_word(data_out, last, "offset");
    endtask

    task automatic summarize();
        $display("error_cnt %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        repeat (5) @(posedge clock);
        #1;
        chk_word(data_out, '0, "reset data");
        chk_bit(empty_flag_n, 1'b0, "reset empty");
        chk_bit(full_flag_n, 1'b1, "reset full");
        chk_bit(almost_empty_flag_n, 1'b0, "reset aempty");
        @(posedge clock);
        #1;
        arst_n = 1'b1;
        offs_rd();
        offs_rd();
        offs_wr(1'b0, 18'(rnd() % 64));
        push(18'(rnd()));
        offs_wr(1'b1, '1);
        offs_wr(1'b0, 18'(rnd() % 64));
        offs_rd();
        offs_rd();
        pop(1'b0);
        pop(1'b1);
        pop(1'b0);
        repeat (3) push(18'(rnd()));
        pop(1'b1);
        repeat (3) pop(1'b0);
        i_fifo_port_agent.retransmit();
        rptr = 0;
        pop(1'b1);
        repeat (4) pop(1'b0);
        while (wptr - rptr < DEPTH_T) push(18'(rnd()));
        push(18'(rnd()));
        flag_sync_select_n = 1'b1;
        pop(1'b1);
        while (wptr != rptr) pop(1'b0);
        pop(1'b0);
        summarize();
    end

    initial begin
        #(8 * 20000);
        error_cnt++;
        $display("mismatch at %0t: watchdog expired", $time);
        summarize();
    end
endmodule // test_sync_fifo_prog_flags
